// [cpu_instruction_timing_decode.sv]
// Instruction length, cycle stall and operand decode for the core
`timescale 1ns/100ps
`include "cpu_timing_defs.svh"
// Functional notes
// RL1: Accumulator-bank moves 1/1, load/store 2/2
// RL2: Direct-direct and immediate-direct moves 3/3
// RL3: Internal indirect single-byte forms take two cycles
// RL4: Data pointer immediate load 3 bytes 3 cycles
// RL5: Both code reads one byte three cycles
// RL6: All external data moves one byte three cycles
// RL7: Nibble exchange swaps low nibbles only
// RL8: Carry ops 1/1, direct bit ops 2/2
// RL9: Carry AND/OR with bit 2/2 into carry
// RL10: Carry/zero jumps two cycles, taken three
// RL11: Bit jumps 3/4; clear variant clears set bit
// RL12: Page call 2/3, far call 3/4
// RL13: Both returns one byte five cycles
// RL14: Page/short/indirect jump 3, far jump 4
// RL15: Compare jump 3/4, indirect form 4/5
// RL16: Decrement jump bank 2/3, direct 3/4
// RL17: No-op and unused opcode both 1/1
// RL18: Relative target is next address plus signed
// RL19: Page target keeps upper next-address bits
// RL20: Direct low half RAM, high half special
// RL21: Index registers 0/1, bank registers 0-7
// RL22: Separate program and data spaces by type
// RL23: Status bits 3-4 select register bank
// RL24: High indirect reaches RAM, direct special space
// RL25: Issue stalls until cycle count elapses
module cpu_instruction_timing_decode (
  input  wire logic        clk,           // 50 MHz system clock
  input  wire logic        rst_n,         // Async reset, active low
  input  wire logic        issueValid,    // Instruction offered
  input  wire logic [7:0]  opcode,        // Opcode byte
  input  wire logic [7:0]  operand1,      // First operand byte
  input  wire logic [7:0]  operand2,      // Second operand byte
  input  wire logic [15:0] nextPc,        // Next instruction address
  input  wire logic        branchCond,    // Branch condition true
  input  wire logic [7:0]  accValue,      // Accumulator
  input  wire logic [15:0] dataPointer,   // Data pointer
  input  wire logic [7:0]  indexValue,    // Selected index register
  input  wire logic [7:0]  memValue,      // Indirect data byte
  input  wire logic [7:0]  programStatus, // Status word
  output logic             issueReady,    // Can take an instruction
  output logic             execValid,     // Decode result pulse
  output logic [1:0]       instrLength,   // Byte length
  output logic [2:0]       cycleCount,    // Cycles incl. taken branch
  output logic             branchTaken,   // Program counter reloads
  output logic [15:0]      targetPc,      // Branch target
  output logic [7:0]       regAddr,       // Register file address
  output logic [7:0]       dataAddr,      // Internal data address
  output logic             specialSelect, // Special register space
  output logic             indirectAccess, // Indirect data access
  output logic [1:0]       memSpace,      // 0 data, 1 code, 2 ext
  output logic [15:0]      memAddr,       // Code or external address
  output logic             knownOpcode,   // Opcode in decoded set
  output logic             clearBitReq,   // Clear tested bit pulse
  output logic [7:0]       nibbleAcc,     // Accumulator after swap
  output logic [7:0]       nibbleMem      // Memory byte after swap
);
  cpu_decode_if dec ();
  dec_pkg::state_e state_q;
  logic [2:0]      waitCnt_q;
  logic [2:0]      cycles;
  logic            taken;
  logic            accept;
  logic [15:0]     tgt;
  logic [7:0]      rAddr;
  logic [7:0]      dAddr;
  logic            spSel;
  logic            ind;
  dec_pkg::space_e space;
  logic [15:0]     mAddr;

  // ========================================================================
  // Decode submodules
  assign dec.opcode = opcode;

  cpu_opcode_table u_table (
    .dec (dec)
  );

  cpu_operand_address u_addr (
    .dec           (dec),
    .operand1      (operand1),
    .operand2      (operand2),
    .nextPc        (nextPc),
    .accValue      (accValue),
    .dataPointer   (dataPointer),
    .indexValue    (indexValue),
    .programStatus (programStatus),
    .targetPc      (tgt),
    .regAddr       (rAddr),
    .dataAddr      (dAddr),
    .specialSelect (spSel),
    .indirect      (ind),
    .space         (space),
    .memAddr       (mAddr)
  );

  // ========================================================================
  // Taken decision and cycle count
  assign accept = issueValid && issueReady;
  // Unconditional transfers always reload, conditional ones on branchCond
  assign taken = (dec.info.jump != dec_pkg::J_NONE) &&
                 (!dec.info.cond || branchCond);
  assign cycles = dec.info.base +
                  ((dec.info.cond && branchCond) ? `TAKEN_EXTRA : 3'h0);
  // see RL10 see RL11 see RL15 see RL16

  // ========================================================================
  // Issue stall: next accept exactly cycleCount clocks after this one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q    <= dec_pkg::ST_IDLE;
      waitCnt_q  <= 3'h0;
      issueReady <= 1'h1;
    end else begin
      case (state_q)
        dec_pkg::ST_IDLE: begin
          if (accept && cycles != `CYC_1) begin // see RL25
            state_q    <= dec_pkg::ST_BUSY;
            waitCnt_q  <= 3'(cycles - `CYC_1);
            issueReady <= 1'h0;
          end
        end
        dec_pkg::ST_BUSY: begin
          waitCnt_q <= 3'(waitCnt_q - 3'h1);
          if (waitCnt_q == 3'h1) begin // see RL25
            state_q    <= dec_pkg::ST_IDLE;
            issueReady <= 1'h1;
          end
        end
        default: begin
          state_q    <= dec_pkg::ST_IDLE;
          waitCnt_q  <= 3'h0;
          issueReady <= 1'h1;
        end
      endcase
    end
  end

  // ========================================================================
  // Decoded results, held until the next accepted instruction
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      instrLength    <= `LEN_1;
      cycleCount     <= `CYC_1;
      branchTaken    <= 1'h0;
      targetPc       <= 16'h0000;
      regAddr        <= 8'h00;
      dataAddr       <= 8'h00;
      specialSelect  <= 1'h0;
      indirectAccess <= 1'h0;
      memSpace       <= 2'h0;
      memAddr        <= 16'h0000;
      knownOpcode    <= 1'h0;
    end else if (accept) begin
      instrLength    <= dec.info.len;
      cycleCount     <= cycles; // see RL25
      branchTaken    <= taken;
      targetPc       <= tgt; // see RL18 see RL19
      regAddr        <= rAddr; // see RL21 see RL23
      dataAddr       <= dAddr;
      specialSelect  <= spSel; // see RL20 see RL24
      indirectAccess <= ind;
      memSpace       <= space; // see RL22
      memAddr        <= mAddr;
      knownOpcode    <= dec.info.known;
    end
  end

  // ========================================================================
  // One-cycle strobes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      execValid   <= 1'h0;
      clearBitReq <= 1'h0;
    end else begin
      execValid   <= accept;
      // Clear only when the tested bit was set, i.e. the jump is taken
      clearBitReq <= accept && opcode == `OP_BIT_JUMP_CLR &&
                     branchCond; // see RL11
    end
  end

  // ========================================================================
  // Nibble exchange data path; other bytes pass untouched
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nibbleAcc <= 8'h00;
      nibbleMem <= 8'h00;
    end else if (accept && opcode[7:1] == 7'h6B) begin
      nibbleAcc <= {accValue[7:4], memValue[3:0]}; // see RL7
      nibbleMem <= {memValue[7:4], accValue[3:0]};
    end
  end

  // ========================================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  bank_move_a: assert property (accept && opcode[7:4] == 4'hE &&
      opcode[3] |=> instrLength == `LEN_1 && cycleCount == `CYC_1) // RL1
    else $error("bank move length or cycles wrong");
  dir_dir_a: assert property (accept && (opcode == `OP_MOV_DIR_DIR ||
      opcode == `OP_MOV_DIR_IMM) |=> instrLength == `LEN_3 &&
      cycleCount == `CYC_3) // RL2
    else $error("three byte move timing wrong");
  indirect_cyc_a: assert property (accept && opcode[7:6] == 2'h3 &&
      opcode[3:1] == 3'h3 |=> cycleCount == `CYC_2 &&
      instrLength == `LEN_1 && indirectAccess) // RL3
    else $error("indirect move timing wrong");
  pointer_load_a: assert property (accept &&
      opcode == `OP_LOAD_POINTER |=> instrLength == `LEN_3 &&
      cycleCount == `CYC_3 && !issueReady ##2 issueReady) // RL4
    else $error("pointer load timing wrong");
  code_read_a: assert property (accept && (opcode == `OP_CODE_READ_PC ||
      opcode == `OP_CODE_READ_PTR) |=> cycleCount == `CYC_3 &&
      memSpace == dec_pkg::SP_CODE) // RL5
    else $error("code read timing or space wrong");
  ext_move_a: assert property (accept &&
      opcode == `OP_EXT_READ_PTR |=> cycleCount == `CYC_3 &&
      memSpace == dec_pkg::SP_EXT && memAddr == $past(dataPointer)) // RL6
    else $error("external move wrong");
  nibble_swap_a: assert property (accept &&
      opcode == `OP_NIBBLE_XCHG |=>
      nibbleAcc == {$past(accValue[7:4]), $past(memValue[3:0])} &&
      nibbleMem == {$past(memValue[7:4]), $past(accValue[3:0])}) // RL7
    else $error("nibble exchange wrong");
  carry_ops_a: assert property (accept && (opcode == `OP_CLR_CARRY ||
      opcode == `OP_CLR_BIT) |=> cycleCount == 3'(instrLength)) // RL8
    else $error("carry or bit op timing wrong");
  carry_logic_a: assert property (accept &&
      opcode == `OP_AND_CARRY_BIT |=> instrLength == `LEN_2 &&
      cycleCount == `CYC_2 && specialSelect == $past(operand1[7])) // RL9
    else $error("carry logic op wrong");
  cond_jump_a: assert property (accept && opcode == `OP_JUMP_CARRY |=>
      cycleCount == (branchTaken ? `CYC_3 : `CYC_2) &&
      branchTaken == $past(branchCond)) // RL10
    else $error("conditional jump timing wrong");
  bit_clear_a: assert property (accept && opcode == `OP_BIT_JUMP_CLR |=>
      clearBitReq == $past(branchCond) &&
      cycleCount == (clearBitReq ? `CYC_4 : `CYC_3)) // RL11
    else $error("bit jump clear wrong");
  far_call_a: assert property (accept && opcode == `OP_FAR_CALL |=>
      cycleCount == `CYC_4 && instrLength == `LEN_3 &&
      targetPc == {$past(operand1), $past(operand2)}) // RL12
    else $error("far call wrong");
  return_a: assert property (accept && (opcode == `OP_RETURN ||
      opcode == `OP_INT_RETURN) |=> !issueReady [*4] ##1 issueReady) // RL13
    else $error("return stall wrong");
  short_jump_a: assert property (accept && opcode == `OP_SHORT_JUMP |=>
      cycleCount == `CYC_3 && branchTaken) // RL14
    else $error("short jump timing wrong");
  cmp_ind_a: assert property (accept && opcode == `OP_COMPARE_IND |=>
      cycleCount == ($past(branchCond) ? `CYC_5 : `CYC_4)) // RL15
    else $error("indirect compare timing wrong");
  dec_jump_a: assert property (accept && opcode == `OP_DEC_JUMP_DIR |=>
      instrLength == `LEN_3 &&
      cycleCount == ($past(branchCond) ? `CYC_4 : `CYC_3)) // RL16
    else $error("direct decrement jump wrong");
  nop_alias_a: assert property (accept && (opcode == `OP_NOP_ALIAS ||
      opcode == `OP_NOP) |=> instrLength == `LEN_1 &&
      cycleCount == `CYC_1 && !branchTaken && issueReady) // RL17
    else $error("no-op alias wrong");
  rel_target_a: assert property (accept && opcode == `OP_SHORT_JUMP |=>
      targetPc == 16'($past(nextPc) +
      {{8{$past(operand1[7])}}, $past(operand1)})) // RL18
    else $error("relative target wrong");
  page_target_a: assert property (accept && opcode[4:0] == 5'h01 |=>
      targetPc[15:11] == $past(nextPc[15:11]) &&
      targetPc[10:8] == $past(opcode[7:5])) // RL19
    else $error("page target wrong");
  direct_space_a: assert property (accept && opcode == 8'hE5 |=>
      specialSelect == $past(operand1[7]) &&
      dataAddr == $past(operand1)) // RL20
    else $error("direct space select wrong");
  bank_addr_a: assert property (accept && opcode[7:3] == 5'h1D |=>
      regAddr == {3'h0, $past(programStatus[4:3]),
      $past(opcode[2:0])}) // RL21
    else $error("bank register address wrong");
  bank_select_a: assert property (accept && opcode[7:1] == 7'h73 |=>
      regAddr[4:3] == $past(programStatus[4:3]) &&
      regAddr[2:1] == 2'h0) // RL23
    else $error("bank select wrong");
  high_indirect_a: assert property (accept && opcode[7:1] == 7'h73 |=>
      !specialSelect && dataAddr == $past(indexValue)) // RL24
    else $error("indirect reached special space");
  space_kind_a: assert property (accept && opcode == `OP_MOV_DIR_DIR |=>
      memSpace == dec_pkg::SP_DATA) // RL22
    else $error("data move left data space");
  stall_len_a: assert property (accept && cycles == `CYC_3 |=>
      !issueReady [*2] ##1 issueReady) // RL25
    else $error("issue stall length wrong");

  far_jump_c: cover property (accept && opcode == `OP_FAR_JUMP);
  taken_c: cover property (accept && dec.info.cond && branchCond);
  b2b_c: cover property (accept ##1 accept);
  ret_c: cover property (accept && opcode == `OP_INT_RETURN);
endmodule // cpu_instruction_timing_decode

// [cpu_timing_defs.svh]
// Constants for the instruction timing decode block
`ifndef CPU_TIMING_DEFS_SVH
`define CPU_TIMING_DEFS_SVH
// ==========================================================================
// Byte lengths and clock counts
`define LEN_1 2'h1
`define LEN_2 2'h2
`define LEN_3 2'h3
`define CYC_1 3'h1
`define CYC_2 3'h2
`define CYC_3 3'h3
`define CYC_4 3'h4
`define CYC_5 3'h5
`define TAKEN_EXTRA 3'h1
// ==========================================================================
// Field positions
`define BANK_SEL_LSB 3
`define BANK_SEL_MSB 4
`define SPECIAL_SEL_BIT 7
`define PAGE_LSB 11
// ==========================================================================
// Single opcodes
`define OP_NOP 8'h00
`define OP_NOP_ALIAS 8'hA5
`define OP_MOV_DIR_DIR 8'h85
`define OP_MOV_DIR_IMM 8'h75
`define OP_LOAD_POINTER 8'h90
`define OP_CODE_READ_PC 8'h83
`define OP_CODE_READ_PTR 8'h93
`define OP_EXT_READ_PTR 8'hE0
`define OP_NIBBLE_XCHG 8'hD6
`define OP_CLR_CARRY 8'hC3
`define OP_CLR_BIT 8'hC2
`define OP_AND_CARRY_BIT 8'h82
`define OP_JUMP_CARRY 8'h40
`define OP_BIT_JUMP_CLR 8'h10
`define OP_FAR_CALL 8'h12
`define OP_FAR_JUMP 8'h02
`define OP_RETURN 8'h22
`define OP_INT_RETURN 8'h32
`define OP_SHORT_JUMP 8'h80
`define OP_JUMP_INDIR 8'h73
`define OP_COMPARE_IND 8'hB6
`define OP_DEC_JUMP_DIR 8'hD5
`endif

// [dec_pkg.sv]
// Types shared by the instruction timing decode modules
package dec_pkg;
  // ========================================================================
  // Branch target source
  typedef enum logic [2:0] {
    J_NONE, J_REL1, J_REL2, J_PAGE, J_FAR, J_INDIR, J_RET
  } jump_e;
  typedef enum logic [1:0] {SP_DATA, SP_CODE, SP_EXT} space_e;
  typedef enum logic [1:0] {ST_IDLE = 2'h1, ST_BUSY = 2'h2} state_e;
  typedef struct packed {
    logic       known;
    logic [1:0] len;
    logic [2:0] base;
    logic       cond;
    jump_e      jump;
    logic       direct;
  } decode_s;
endpackage

// [cpu_decode_if.sv]
// Opcode and decoded class shared between table and operand logic
`timescale 1ns/100ps
interface cpu_decode_if;
  logic [7:0]       opcode;
  dec_pkg::decode_s info;
  modport table_mp (input opcode, output info);
  modport reader (input opcode, input info);
endinterface // cpu_decode_if

// [cpu_opcode_table.sv]
// Opcode to byte length, cycle count and branch class table
`timescale 1ns/100ps
`include "cpu_timing_defs.svh"
module cpu_opcode_table (
  cpu_decode_if.table_mp dec // Opcode in, class out
);
  function automatic dec_pkg::decode_s mk(input logic [1:0] len,
      input logic [2:0] cyc, input logic cond,
      input dec_pkg::jump_e jmp, input logic dir);
    mk = '{known: 1'h1, len: len, base: cyc, cond: cond, jump: jmp,
           direct: dir};
  endfunction

  // ========================================================================
  // Decode table
  always_comb begin
    dec.info = '{known: 1'h0, len: `LEN_1, base: `CYC_1, cond: 1'h0,
                 jump: dec_pkg::J_NONE, direct: 1'h0};
    casez (dec.opcode)
      8'b111?_1???, 8'b1100_1???, `OP_CLR_CARRY, 8'hD3, 8'hB3, `OP_NOP,
      `OP_NOP_ALIAS: begin // see RL1 see RL8 see RL17
        dec.info = mk(`LEN_1, `CYC_1, 1'h0, dec_pkg::J_NONE, 1'h0);
      end
      8'hE5, 8'hF5, 8'b1000_1???, 8'b1010_1???, 8'b10?0_011?, 8'hC5,
      8'hC0, 8'hD0, `OP_CLR_BIT, 8'hD2, 8'hB2, `OP_AND_CARRY_BIT, 8'hB0,
      8'h72, 8'hA0, 8'hA2, 8'h92: begin // see RL1 see RL8 see RL9
        dec.info = mk(`LEN_2, `CYC_2, 1'h0, dec_pkg::J_NONE, 1'h1);
      end
      8'h74, 8'b0111_1???, 8'b0111_011?: begin // see RL1
        dec.info = mk(`LEN_2, `CYC_2, 1'h0, dec_pkg::J_NONE, 1'h0);
      end
      8'b11??_011?: begin // see RL3 see RL7
        dec.info = mk(`LEN_1, `CYC_2, 1'h0, dec_pkg::J_NONE, 1'h0);
      end
      `OP_MOV_DIR_DIR, `OP_MOV_DIR_IMM: begin // see RL2
        dec.info = mk(`LEN_3, `CYC_3, 1'h0, dec_pkg::J_NONE, 1'h1);
      end
      `OP_LOAD_POINTER: begin // see RL4
        dec.info = mk(`LEN_3, `CYC_3, 1'h0, dec_pkg::J_NONE, 1'h0);
      end
      `OP_CODE_READ_PC, `OP_CODE_READ_PTR, 8'b111?_0000,
      8'b111?_001?: begin // see RL5 see RL6
        dec.info = mk(`LEN_1, `CYC_3, 1'h0, dec_pkg::J_NONE, 1'h0);
      end
      `OP_JUMP_CARRY, 8'h50, 8'h60, 8'h70, 8'b1101_1???: begin // see RL10
        dec.info = mk(`LEN_2, `CYC_2, 1'h1, dec_pkg::J_REL1, 1'h0);
      end
      `OP_SHORT_JUMP: begin // see RL14
        dec.info = mk(`LEN_2, `CYC_3, 1'h0, dec_pkg::J_REL1, 1'h0);
      end
      `OP_BIT_JUMP_CLR, 8'h20, 8'h30, 8'hB5, `OP_DEC_JUMP_DIR: begin
        dec.info = mk(`LEN_3, `CYC_3, 1'h1, dec_pkg::J_REL2, 1'h1);
      end // see RL11 see RL15 see RL16
      8'hB4, 8'b1011_1???: begin // see RL15
        dec.info = mk(`LEN_3, `CYC_3, 1'h1, dec_pkg::J_REL2, 1'h0);
      end
      8'b1011_011?: begin // see RL15
        dec.info = mk(`LEN_3, `CYC_4, 1'h1, dec_pkg::J_REL2, 1'h0);
      end
      8'b????_0001: begin // see RL12 see RL14
        dec.info = mk(`LEN_2, `CYC_3, 1'h0, dec_pkg::J_PAGE, 1'h0);
      end
      `OP_FAR_JUMP, `OP_FAR_CALL: begin // see RL12 see RL14
        dec.info = mk(`LEN_3, `CYC_4, 1'h0, dec_pkg::J_FAR, 1'h0);
      end
      `OP_RETURN, `OP_INT_RETURN: begin // see RL13
        dec.info = mk(`LEN_1, `CYC_5, 1'h0, dec_pkg::J_RET, 1'h0);
      end
      `OP_JUMP_INDIR: begin // see RL14
        dec.info = mk(`LEN_1, `CYC_3, 1'h0, dec_pkg::J_INDIR, 1'h0);
      end
      default: begin
      end
    endcase
  end
endmodule // cpu_opcode_table

// [cpu_operand_address.sv]
// Operand addresses, memory space and branch target generation
`timescale 1ns/100ps
`include "cpu_timing_defs.svh"
module cpu_operand_address (
  cpu_decode_if.reader    dec,           // Opcode and class
  input  wire logic [7:0]  operand1,      // First operand byte
  input  wire logic [7:0]  operand2,      // Second operand byte
  input  wire logic [15:0] nextPc,        // Next instruction address
  input  wire logic [7:0]  accValue,      // Accumulator
  input  wire logic [15:0] dataPointer,   // Data pointer
  input  wire logic [7:0]  indexValue,    // Selected index register
  input  wire logic [7:0]  programStatus, // Status word
  output logic [15:0]      targetPc,      // Branch target
  output logic [7:0]       regAddr,       // Register file address
  output logic [7:0]       dataAddr,      // Internal data address
  output logic             specialSelect, // Special register space
  output logic             indirect,      // Indirect access
  output dec_pkg::space_e  space,         // Memory space
  output logic [15:0]      memAddr        // Code or external address
);
  logic [1:0] bankSel;
  logic [7:0] rel;
  // ========================================================================
  // Space selection by instruction type, not by address
  assign space = (dec.opcode == `OP_CODE_READ_PC ||
                  dec.opcode == `OP_CODE_READ_PTR) ? dec_pkg::SP_CODE :
                 (dec.opcode[7:5] == 3'h7 && dec.opcode[3:2] == 2'h0 &&
                  dec.opcode[1:0] != 2'h1) ? dec_pkg::SP_EXT :
                 dec_pkg::SP_DATA; // see RL22
  assign indirect = dec.info.known && (dec.opcode[3:1] == 3'h3 ||
                    (space == dec_pkg::SP_EXT && dec.opcode[1]));
  assign bankSel = programStatus[`BANK_SEL_MSB:`BANK_SEL_LSB]; // see RL23
  // Only the first two registers of a bank act as pointers
  assign regAddr = indirect ? {3'h0, bankSel, 2'h0, dec.opcode[0]} :
                   {3'h0, bankSel, dec.opcode[2:0]}; // see RL21
  // Above the low half, direct reaches special registers, indirect RAM
  assign dataAddr = indirect ? indexValue : operand1; // see RL24
  assign specialSelect = dec.info.direct && !indirect &&
                         operand1[`SPECIAL_SEL_BIT]; // see RL20
  assign memAddr = (space == dec_pkg::SP_CODE) ?
                   16'(accValue + (dec.opcode[4] ? dataPointer : nextPc)) :
                   (dec.opcode[1] ? {8'h00, indexValue} : dataPointer);
  // ========================================================================
  // Branch targets
  assign rel = (dec.info.jump == dec_pkg::J_REL1) ? operand1 : operand2;
  always_comb begin
    case (dec.info.jump)
      dec_pkg::J_REL1, dec_pkg::J_REL2: begin
        targetPc = 16'(nextPc + {{8{rel[7]}}, rel}); // see RL18
      end
      dec_pkg::J_PAGE: begin
        targetPc = {nextPc[15:`PAGE_LSB], dec.opcode[7:5], operand1};
      end // see RL19
      dec_pkg::J_FAR: begin
        targetPc = {operand1, operand2};
      end
      dec_pkg::J_INDIR: begin
        targetPc = 16'(dataPointer + {8'h00, accValue});
      end
      default: begin
        targetPc = nextPc;
      end
    endcase
  end
endmodule // cpu_operand_address

// [cpu_instruction_timing_decode_tb.sv]
// Self-checking bench for the instruction timing decode block
`timescale 1ns/100ps
module cpu_instruction_timing_decode_tb;
  logic clk = 0, rst_n = 0, issueValid = 0, branchCond = 0, clrSeen;
  logic [7:0] opcode = 0, operand1 = 0, operand2 = 0, accValue = 0;
  logic [7:0] indexValue = 0, memValue = 0, programStatus = 0;
  logic [15:0] nextPc = 0, dataPointer = 0, targetPc, memAddr;
  logic issueReady, execValid, branchTaken, specialSelect, indirectAccess;
  logic knownOpcode, clearBitReq;
  logic [1:0] instrLength, memSpace;
  logic [2:0] cycleCount;
  logic [7:0] regAddr, dataAddr, nibbleAcc, nibbleMem;
  int errCount = 0;
  int testsRun = 0;
  always #10 clk = ~clk;
  cpu_instruction_timing_decode dut (.clk, .rst_n, .issueValid, .opcode,
    .operand1, .operand2, .nextPc, .branchCond, .accValue, .dataPointer,
    .indexValue, .memValue, .programStatus, .issueReady, .execValid,
    .instrLength, .cycleCount, .branchTaken, .targetPc, .regAddr,
    .dataAddr, .specialSelect, .indirectAccess, .memSpace, .memAddr,
    .knownOpcode, .clearBitReq, .nibbleAcc, .nibbleMem);
  // ==================================================================
  // Shared drivers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    testsRun++;
    if (got !== exp) begin
      errCount++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Ready must stay low exactly cyc-1 cycles after the accept
  task automatic issue(input logic [7:0] op, input logic [7:0] o1,
      input logic c, input logic [1:0] len, input logic [2:0] cyc);
    int n;
    @(negedge clk);
    opcode = op;
    operand1 = o1;
    branchCond = c;
    issueValid = 1;
    @(negedge clk);
    issueValid = 0;
    clrSeen = clearBitReq;
    chk(execValid, 1);
    chk(instrLength, len);
    chk(cycleCount, cyc);
    n = 1;
    while (issueReady !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    chk(n, cyc);
  endtask
  // ==================================================================
  // Scenarios
  task automatic plainTiming();
    logic [15:0] t[$] = '{16'hE811, 16'hF811, 16'hA822, 16'h7822,
      16'hF522, 16'h8533, 16'h7533, 16'hE612, 16'hF612, 16'hC612,
      16'h9033, 16'h8313, 16'h9313, 16'hE013, 16'hE213, 16'hF013,
      16'hF213, 16'hD612, 16'hC311, 16'hD311, 16'hB311, 16'hC222,
      16'hD222, 16'hB222, 16'h8222, 16'hB022, 16'h7222, 16'hA022,
      16'h1123, 16'h1234, 16'h2215, 16'h3215, 16'h0123, 16'h0234,
      16'h8023, 16'h7313, 16'h0011, 16'hA511};
    foreach (t[i]) begin
      issue(t[i][15:8], 0, 0, t[i][5:4], t[i][2:0]);
      chk(knownOpcode, 1);
    end
  endtask
  task automatic condBranches();
    logic [15:0] t[$] = '{16'h4022, 16'h5022, 16'h6022, 16'h7022,
      16'h2033, 16'h3033, 16'h1033, 16'hB533, 16'hB433, 16'hB833,
      16'hB634, 16'hD822, 16'hD533};
    nextPc = 16'h1000;
    operand2 = 8'hFE;
    foreach (t[i]) begin
      issue(t[i][15:8], 8'hFE, 0, t[i][5:4], t[i][2:0]);
      chk(branchTaken, 0);
      issue(t[i][15:8], 8'hFE, 1, t[i][5:4],
            3'(t[i][2:0] + 3'h1));
      chk(branchTaken, 1);
      chk(targetPc, 16'h0FFE);
      chk(clrSeen, t[i][15:8] == 8'h10);
    end
  endtask
  task automatic pageAndSpaces();
    nextPc = 16'h5800;
    issue(8'hE1, 8'h34, 0, 2, 3);
    chk(targetPc, 16'h5F34);
    issue(8'hF1, 8'h34, 0, 2, 3);
    chk(targetPc, 16'h5F34);
    programStatus = 8'h18;
    indexValue = 8'hC0;
    dataPointer = 16'h1234;
    accValue = 8'hAB;
    memValue = 8'h5C;
    issue(8'hE5, 8'h90, 0, 2, 2);
    chk({specialSelect, dataAddr}, 16'h0190);
    issue(8'hE5, 8'h40, 0, 2, 2);
    chk(specialSelect, 0);
    issue(8'hE7, 0, 0, 1, 2);
    chk({indirectAccess, specialSelect, regAddr}, 16'h0219);
    chk(dataAddr, 8'hC0);
    issue(8'hED, 0, 0, 1, 1);
    chk(regAddr, 8'h1D);
    issue(8'h93, 0, 0, 1, 3);
    chk(memSpace, 2'h1);
    chk(memAddr, 16'h12DF);
    issue(8'hE0, 0, 0, 1, 3);
    chk(memSpace, 2'h2);
    chk(memAddr, 16'h1234);
    issue(8'hD6, 0, 0, 1, 2);
    chk({nibbleAcc, nibbleMem}, 16'hAC5B);
    issue(8'h24, 0, 0, 1, 1);
    chk(knownOpcode, 0);
  endtask
  task automatic tallyAndFinish();
    $display("checks %0d errors %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge clk);
    chk({issueReady, execValid, cycleCount}, 5'h11);
    rst_n = 1;
    plainTiming();
    condBranches();
    pageAndSpaces();
    tallyAndFinish();
  end
  // Whole run needs well under 1000 cycles
  initial begin
    #50000;
    errCount++;
    tallyAndFinish();
  end
endmodule // cpu_instruction_timing_decode_tb
